// ==== msl_driver.sv ====
// Module status indicator driver with APB registers and network test sequencing.
`timescale 1ns/1ns
module msl_driver
#(
    parameter int unsigned PHASE_LEN = msl_pkg::PHASE_CYC // Cycles in each timed test phase.
)
(
    input  wire logic                      pclk,           // System clock, 25 MHz.
    input  wire logic                      presetn,        // Asynchronous reset, active low.
    input  wire logic                      psel,           // APB select.
    input  wire logic                      penable,        // APB access phase.
    input  wire logic                      pwrite,         // APB write.
    input  wire logic [11:0]               paddr,          // APB byte address.
    input  wire logic [31:0]               pwdata,         // APB write data.
    output logic                           pready,         // APB ready.
    output logic [31:0]                    prdata,         // APB read data.
    output logic                           pslverr,        // APB error.
    output msl_pkg::msl_led_t              module_status_indicator, // LED drives.
    output logic [msl_pkg::NET_MAX-1:0]    net_test_start  // Network test start pulses.
);
    import msl_pkg::*;

    logic [4:0]       ctrl_q;       // Control bits.
    logic [31:0]      flash_q;      // Flash half period.
    logic [1:0]       net_q;        // Bit0 simultaneous; bit1 enable net tests.
    msl_state_t       state_q;      // Displayed state.
    msl_state_t       state_d;      // Next displayed state.
    logic [31:0]      phase_cnt_q;  // Self-test phase counter.
    logic [31:0]      flash_cnt_q;  // Flash counter.
    logic             blink_q;      // Flash phase.
    logic [2:0]       net_idx_q;    // Next network test to start.
    logic             net_run_q;    // Network sequencing active.
    logic             acc;          // APB access cycle.
    logic             test_start;   // Self-test restart request.
    logic [31:0]      stat_word;    // Status readback.

    // Zero-wait slave: every access completes in its first access cycle.
    assign acc     = psel && penable;
    assign pready  = 1'b1;
    // A restart is seen in the access cycle of the control write that carries it.
    assign test_start = acc && pwrite && (paddr == OFF_CTRL) && pwdata[CTRL_START];

    // Unmapped addresses answer with an error and no effect.
    always_comb
    begin
        pslverr = acc && !(paddr == OFF_CTRL || paddr == OFF_STAT ||
                           paddr == OFF_FLASH || paddr == OFF_NET);
    end

    // Register writes; the start bit self-clears.
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            ctrl_q  <= CTRL_RST;
            flash_q <= FLASH_RST;
            net_q   <= NET_RST;
        end
        else if (acc && pwrite)
        begin
            // Plain field stores on matching offsets.
            if (paddr == OFF_CTRL)
                ctrl_q <= {1'b0, pwdata[3:0]};
            if (paddr == OFF_FLASH)
                // Zero is stored as one so that the flash counter cannot stall.
                flash_q <= (pwdata == 32'h0) ? 32'h1 : pwdata;
            if (paddr == OFF_NET)
                net_q <= pwdata[1:0];
        end
    end

    // Status word: state, blink phase and net progress.
    assign stat_word = {24'h0, net_run_q, net_idx_q, blink_q, state_q};

    // Read data registered at the access edge.
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            prdata <= 32'h0;
        else if (psel && !penable && !pwrite)
        begin
            // Capture in setup so data is valid during access.
            unique case (paddr)
                OFF_CTRL:  prdata <= {27'h0, ctrl_q};
                OFF_STAT:  prdata <= stat_word;
                OFF_FLASH: prdata <= flash_q;
                OFF_NET:   prdata <= {30'h0, net_q};
                default:   prdata <= 32'h0;
            endcase
        end
    end

    // Next state: test phases first, then priority of fault and status.
    always_comb
    begin
        state_d = state_q;
        if (test_start)
            state_d = MSL_TEST_G1;
        else
        begin
            unique case (state_q)
                MSL_OFF:     state_d = MSL_TEST_G1;
                MSL_TEST_G1:
                    if (phase_cnt_q == PHASE_LEN - 1) state_d = MSL_TEST_R;
                MSL_TEST_R:
                    if (phase_cnt_q == PHASE_LEN - 1) state_d = MSL_TEST_G2;
                MSL_TEST_G2, MSL_UNREC, MSL_RECOV, MSL_STANDBY, MSL_OPER:
                begin
                    // Self-test green holds until done; then normal state.
                    if (state_q == MSL_TEST_G2 && !ctrl_q[CTRL_DONE])
                        state_d = MSL_TEST_G2;
                    else if (ctrl_q[CTRL_UNREC])
                        state_d = MSL_UNREC;
                    else if (ctrl_q[CTRL_RECOV])
                        state_d = MSL_RECOV;
                    else if (!ctrl_q[CTRL_OPER])
                        state_d = MSL_STANDBY;
                    else
                        state_d = MSL_OPER;
                end
            endcase
        end
    end

    // State register and phase counter.
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            state_q     <= MSL_OFF;
            phase_cnt_q <= 32'h0;
        end
        else
        begin
            state_q <= state_d;
            // Counter restarts on every state change, and on a restart request so that
            // a restart inside the first phase still gives that phase its full length.
            if (state_d != state_q || test_start)
                phase_cnt_q <= 32'h0;
            else
                phase_cnt_q <= phase_cnt_q + 32'h1;
        end
    end

    // Free-running flash generator with configurable half period.
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            flash_cnt_q <= 32'h0;
            blink_q     <= 1'b1;
        end
        // Compared with at-least, so that a shorter new period takes effect at once.
        else if (flash_cnt_q >= flash_q - 32'h1)
        begin
            flash_cnt_q <= 32'h0;
            blink_q     <= !blink_q;
        end
        else
            flash_cnt_q <= flash_cnt_q + 32'h1;
    end

    // Colour drives from the displayed state.
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            module_status_indicator <= '0;
        else
        begin
            unique case (state_d)
                MSL_OFF:     module_status_indicator <= '0;
                MSL_TEST_G1: module_status_indicator <= '{red: 1'b0, green: 1'b1};
                MSL_TEST_R:  module_status_indicator <= '{red: 1'b1, green: 1'b0};
                MSL_TEST_G2: module_status_indicator <= '{red: 1'b0, green: 1'b1};
                MSL_UNREC:   module_status_indicator <= '{red: 1'b1, green: 1'b0};
                MSL_RECOV:   module_status_indicator <= '{red: blink_q, green: 1'b0};
                MSL_STANDBY: module_status_indicator <= '{red: 1'b0, green: blink_q};
                MSL_OPER:    module_status_indicator <= '{red: 1'b0, green: 1'b1};
            endcase
        end
    end

    // Network tests start only once the module test has begun.
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            net_idx_q      <= 3'h0;
            net_run_q      <= 1'b0;
            net_test_start <= '0;
        end
        else
        begin
            net_test_start <= '0;
            // A restart while the first phase runs begins the sequence again as well.
            if ((state_d == MSL_TEST_G1 && state_q != MSL_TEST_G1) || test_start)
            begin
                // Module test begins this edge; network follows, never before.
                net_run_q <= net_q[1];
                net_idx_q <= 3'h0;
            end
            else if (net_run_q)
            begin
                if (net_q[0])
                begin
                    // All network tests launched together.
                    net_test_start <= '1;
                    net_run_q      <= 1'b0;
                end
                else if (phase_cnt_q == 32'h0 || net_idx_q == 3'h0)
                begin
                    // One indicator per module-test phase boundary.
                    net_test_start[net_idx_q[1:0]] <= 1'b1;
                    net_idx_q <= net_idx_q + 3'h1;
                    if (net_idx_q == 3'(NET_MAX - 1))
                        net_run_q <= 1'b0;
                end
            end
        end
    end

endmodule : msl_driver

// ==== msl_pkg.sv ====
// Package for the module status indicator driver: constants, register map and carrier types.
// Contract
// - Operational: steady green, red off.
// - Standby: flash green, red off.
// - Recoverable or bad configuration: flash red.
// - Unrecoverable fault: steady red, green off.
// - Self-test: green, red, green until done.
// - Module test starts no later than network.
// - Network tests run in succession or together.
// - After self-test, show normal operating state.
package msl_pkg;

    // Clock rate and phase timing.
    localparam int unsigned CLK_HZ       = 25_000_000;             // System clock rate.
    localparam int unsigned PHASE_MS     = 250;                    // Each test phase, 0.25 s.
    localparam int unsigned PHASE_CYC    = CLK_HZ / 1000 * PHASE_MS; // Phase length in cycles.
    localparam int unsigned HALF_FLASH_MS  = 500;                  // Default flash half period.
    localparam int unsigned HALF_FLASH_CYC = CLK_HZ / 1000 * HALF_FLASH_MS; // In cycles.

    // Register byte offsets.
    localparam logic [11:0] OFF_CTRL   = 12'h000;  // Status and test control.
    localparam logic [11:0] OFF_STAT   = 12'h004;  // Indicator state readback.
    localparam logic [11:0] OFF_FLASH  = 12'h008;  // Flash half period in cycles.
    localparam logic [11:0] OFF_NET    = 12'h00c;  // Network test sequencing.

    // Control field positions.
    localparam int unsigned CTRL_OPER  = 0;        // Device operating correctly.
    localparam int unsigned CTRL_RECOV = 1;        // Recoverable fault or bad config.
    localparam int unsigned CTRL_UNREC = 2;        // Unrecoverable fault.
    localparam int unsigned CTRL_DONE  = 3;        // Power-up test completed.
    localparam int unsigned CTRL_START = 4;        // Write one to restart self-test.

    // Reset values.
    localparam logic [4:0]  CTRL_RST   = 5'h00;    // No status, test not done.
    localparam logic [31:0] FLASH_RST  = 32'(HALF_FLASH_CYC); // Default half period.
    localparam logic [1:0]  NET_RST    = 2'h0;     // Sequential order, network tests disabled.
    localparam int unsigned NET_MAX    = 4;        // Number of network indicators.

    // Displayed indicator state.
    typedef enum logic [2:0]
    {
        MSL_OFF,
        MSL_TEST_G1,
        MSL_TEST_R,
        MSL_TEST_G2,
        MSL_UNREC,
        MSL_RECOV,
        MSL_STANDBY,
        MSL_OPER
    } msl_state_t;

    // Colour drive pair.
    typedef struct packed
    {
        logic red;                                 // Red drive.
        logic green;                               // Green drive.
    } msl_led_t;

endpackage : msl_pkg

// ==== msl_driver_monitor.sv ====
// Port checker for the status indicator driver.
`timescale 1ns/1ns
module msl_driver_chk
#(
    parameter int unsigned PHASE_LEN = msl_pkg::PHASE_CYC // Cycles in each timed test phase.
)
(
    input wire logic              pclk,    // Clock.
    input wire logic              presetn, // Reset, active low.
    input wire logic              psel,    // Select.
    input wire logic              penable, // Access phase.
    input wire logic              pwrite,  // Write.
    input wire logic [11:0]       paddr,   // Address.
    input wire logic [31:0]       pwdata,  // Write data.
    input wire logic              pready,  // Ready.
    input wire logic [31:0]       prdata,  // Read data.
    input wire logic              pslverr, // Error.
    input wire msl_pkg::msl_led_t module_status_indicator, // Drives.
    input wire logic [3:0]        net_test_start           // Start pulses.
);
    import msl_pkg::*;
    localparam int unsigned END_T = 2 * PHASE_LEN + 3; // Test phases are over.
    logic [31:0] since_q; // Cycles since reset release.
    logic [3:0]  cs_q;    // Shadow of the status bits.
    logic        rst_q;   // A restart was asked for.
    logic        acc;     // Access phase now.
    logic        g;       // Normal display expected.
    logic [1:0]  led;     // Red, green.
    assign acc = psel && penable;
    assign g = since_q > END_T && !rst_q && cs_q[3];
    assign led = module_status_indicator;
    // Counts cycles from reset release and stops once the test is over.
    always_ff @(posedge pclk or negedge presetn)
        if (!presetn) since_q <= 32'h0;
        else if (since_q <= END_T) since_q <= since_q + 32'h1;
    // Follows the status bits that software writes.
    always_ff @(posedge pclk or negedge presetn)
        if (!presetn) cs_q <= 4'h0;
        else if (acc && pwrite && paddr == OFF_CTRL) cs_q <= pwdata[3:0];
    // Notes a restart, after which the test pattern runs again.
    always_ff @(posedge pclk or negedge presetn)
        if (!presetn) rst_q <= 1'b0;
        else if (acc && pwrite && paddr == OFF_CTRL && pwdata[4]) rst_q <= 1'b1;
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    a_ready_always: assert property (acc |-> pready) else $error("ready low");
    a_err_unmapped: assert property (pslverr == (acc && paddr != OFF_CTRL && paddr != OFF_STAT
        && paddr != OFF_FLASH && paddr != OFF_NET)) else $error("error flag wrong");
    a_err_zero: assert property (acc && !pwrite && pslverr |-> prdata == 32'h0)
        else $error("refused read not zero");
    a_reset_green:
        assert property ($rose(presetn) |=> led == 2'b01 [*2]) else $error("no green start");
    a_test_green:
        assert property (since_q >= 2 && since_q < PHASE_LEN |-> led == 2'b01)
        else $error("first phase not green");
    a_test_red:
        assert property (since_q >= PHASE_LEN + 2 && since_q < 2 * PHASE_LEN |-> led == 2'b10)
        else $error("second phase not red");
    a_held_green:
        assert property (since_q > 2 * PHASE_LEN + 1 && !cs_q[3] && !rst_q |-> led == 2'b01)
        else $error("final phase not green");
    a_unrec_steady:
        assert property ((g && cs_q[2]) [*3] |-> led == 2'b10) else $error("not steady red");
    a_oper_steady:
        assert property ((g && cs_q[2:0] == 3'h1) [*3] |-> led == 2'b01) else $error("not green");
    a_recov_red:
        assert property ((g && cs_q[2:1] == 2'h1) [*3] |-> !led[0]) else $error("green in fault");
    a_standby_green:
        assert property ((g && cs_q[2:0] == 3'h0) [*3] |-> !led[1]) else $error("red in standby");
    a_net_shape:
        assert property ($onehot0(net_test_start) || net_test_start == 4'hf) else $error("bad net");
    a_net_order:
        assert property (|net_test_start |-> $past(led) != 2'b00) else $error("net test first");
    c_unrec: cover property (g && cs_q[2]);
    c_red: cover property (since_q == PHASE_LEN + 2);
    c_net_all: cover property (net_test_start == 4'hf);
    c_net_last: cover property (net_test_start == 4'h8);
endmodule : msl_driver_chk
bind msl_driver msl_driver_chk #(.PHASE_LEN(PHASE_LEN)) msl_driver_chk_inst (.pclk(pclk),
    .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .pready(pready), .prdata(prdata), .pslverr(pslverr),
    .module_status_indicator(module_status_indicator), .net_test_start(net_test_start));

// ==== msl_led_model.sv ====
// Model of the bicolour lamp that counts how often each colour lights.
`timescale 1ns/1ns
module msl_led_model
(
    input  wire logic              pclk, // Sampling clock.
    input  wire msl_pkg::msl_led_t led,  // Drives, owned by the host side.
    input  wire logic              clr,  // Clears both counts.
    output int                     rg,   // Green lightings.
    output int                     rr    // Red lightings.
);
    import msl_pkg::*;
    msl_led_t prev_q; // Drives at the previous edge.
    // A colour lights when its drive rises.
    always_ff @(posedge pclk)
    begin
        prev_q <= led;
        rg <= clr ? 0 : rg + int'(led.green && !prev_q.green);
        rr <= clr ? 0 : rr + int'(led.red && !prev_q.red);
    end
endmodule : msl_led_model

// ==== test_module_status_led_driver.sv ====
// Self-checking bench for the status indicator driver.
`timescale 1ns/1ns
module test_module_status_led_driver;
    import msl_pkg::*;
    localparam int unsigned TB_PHASE = 200; // Shortened test phase, keeps the run brief.
    logic        pclk = 1'b0, presetn = 1'b0, clr = 1'b0; // Clock, reset, count clear.
    logic        psel = 1'b0, penable = 1'b0, pwrite = 1'b0; // Bus controls.
    logic [11:0] paddr = 12'h000;                       // Bus address.
    logic [31:0] pwdata = 32'h0, prdata, rd;            // Bus data.
    logic        pready, pslverr, err;                  // Bus answers.
    msl_led_t    led;                                   // Lamp drives.
    logic [3:0]  net;                                   // Network test starts.
    int          rg, rr, miscompares = 0, n_checks = 0; // Counts.
    logic [4:0]  cv [5] = '{5'h09, 5'h08, 5'h0b, 5'h0f, 5'h0a}; // Status written.
    logic [2:0]  st [5] = '{3'h7, 3'h6, 3'h5, 3'h4, 3'h5};      // State expected.
    logic [3:0]  fl [5] = '{4'h3, 4'h9, 4'h6, 4'h3, 4'h6};      // Flash pattern expected.
    logic [1:0]  ld [5] = '{2'h1, 2'h0, 2'h0, 2'h2, 2'h0};      // Steady colour expected.
    always #20 pclk = ~pclk;
    msl_driver #(.PHASE_LEN(TB_PHASE)) msl_driver_inst (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready),
        .prdata(prdata), .pslverr(pslverr), .module_status_indicator(led), .net_test_start(net));
    msl_led_model msl_led_model_inst (.pclk(pclk), .led(led), .clr(clr), .rg(rg), .rr(rr));
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string m);
        n_checks++;
        if (seen !== exp)
        begin
            miscompares++;
            $display("CHECK FAILED t=%0t %s", $time, m);
        end
    endtask : chk
    // One bus transfer; the request holds until ready is seen high.
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask : apb
    // Looks at the drives between edges, where they are settled.
    task automatic see(input logic [1:0] e, input string m);
        @(negedge pclk);
        chk(32'(led), 32'(e), m);
        @(posedge pclk);
    endtask : see
    // Waits, between edges, for the next network start pulse and compares it.
    task automatic wait_net(input logic [3:0] e, input string m);
        int k;
        k = 0;
        do
        begin
            @(negedge pclk);
            k++;
        end
        while (net === 4'h0 && k < 3 * TB_PHASE);
        chk(32'(net), 32'(e), m);
        @(posedge pclk);
    endtask : wait_net
    task automatic tally_and_finish;
        $display("checks %0d mismatches %0d", n_checks, miscompares);
        if (miscompares == 0 && n_checks > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask : tally_and_finish
    initial
    begin
        repeat (3) @(posedge pclk);
        presetn <= 1'b1;
        repeat (2) @(posedge pclk);
        see(2'b01, "start not green");
        apb(1'b0, OFF_STAT, 32'h0);
        chk(32'(rd[2:0]), 32'h1, "not in first phase");
        apb(1'b0, 12'h010, 32'h0);
        chk({31'h0, err}, 32'h1, "unmapped not refused");
        apb(1'b0, OFF_FLASH, 32'h0);
        chk(rd, FLASH_RST, "flash reset value");
        apb(1'b1, OFF_FLASH, 32'h4);
        apb(1'b0, OFF_FLASH, 32'h0);
        chk(rd, 32'h4, "flash period");
        repeat (TB_PHASE) @(posedge pclk);
        see(2'b10, "second phase not red");
        repeat (TB_PHASE) @(posedge pclk);
        see(2'b01, "last phase not green");
        $display("test self_test done");
        for (int i = 0; i < 5; i++)
        begin
            apb(1'b1, OFF_CTRL, 32'(cv[i]));
            repeat (4) @(posedge pclk);
            clr <= 1'b1;
            @(posedge pclk);
            clr <= 1'b0;
            repeat (48) @(posedge pclk);
            apb(1'b0, OFF_STAT, 32'h0);
            chk(32'(rd[2:0]), 32'(st[i]), "state");
            chk({rg >= 4, rr >= 4, rg == 0, rr == 0}, 32'(fl[i]), "flash");
            if (fl[i] == 4'h3) see(ld[i], "steady colour");
        end
        $display("test status_display done");
        apb(1'b1, OFF_NET, 32'h3);
        apb(1'b1, OFF_CTRL, 32'h10);
        repeat (20)
        begin
            @(negedge pclk);
            if (net !== 4'h0) break;
        end
        chk(32'(net), 32'hf, "network starts not together");
        chk(32'(led), 32'h1, "module test not running");
        @(negedge pclk);
        chk(32'(net), 32'h0, "start not a pulse");
        @(posedge pclk);
        // Sequential starts, restarted inside the first phase: one per phase boundary.
        apb(1'b1, OFF_NET, 32'h2);
        apb(1'b1, OFF_CTRL, 32'h10);
        wait_net(4'h1, "first network start");
        wait_net(4'h2, "second network start");
        wait_net(4'h4, "third network start");
        apb(1'b1, OFF_CTRL, 32'h09);
        wait_net(4'h8, "last network start");
        $display("test network_start done");
        tally_and_finish();
    end
    initial
    begin
        repeat (8 * TB_PHASE + 2000) @(posedge pclk);
        miscompares++;
        tally_and_finish();
    end
endmodule : test_module_status_led_driver
